// ===== common/stx_defs.svh
`ifndef STX_DEFS_SVH
`define STX_DEFS_SVH
`define STX_CTRL_OFF 12'h000
`define STX_STAT_OFF 12'h004
`define STX_CTRL_RST 8'h00
`define STX_ST_LOCK 0
`define STX_ST_OOB 1
`define STX_ST_CERR 2
`define STX_MAX_W 160
`define STX_SYNC66 2'h2
`define STX_SYNC67 3'h2
`define STX_RUN_LIMIT 8'h40
`define STX_OOB_HALF 8'h08
`define STX_OOB_BURSTS 4'h4
`endif

// ===== common/stx_pkg.sv
package stx_pkg;
  typedef enum logic [1:0] {
    stx_enc_none,
    stx_enc_8b10b,
    stx_enc_64b66b,
    stx_enc_64b67b
  } stx_enc_t;
  typedef struct packed {
    logic oob_tx;
    logic rx_en;
    logic tx_en;
    stx_enc_t enc;
    logic [2:0] width_sel;
  } stx_ctrl_t;
endpackage

// ===== rtl/stx_datapath.sv
// Operation
// - The transmitter serializes parallel words of 16, 20, 32, 40, 64 or 80 bits, plus 128 or 160 on the wide variant.
// - A transmit clock divided from the bit clock to suit the width is driven out for the core to register its data.
// - The transmit path offers 8B/10B, 64B/66B or 64B/67B encoding, or none.
// - The receiver deserializes the bit stream into words of the same selectable widths.
// - The receiver takes its timing from the data stream and the local clock, with no forwarded clock.
// - The line carries NRZ bits, with matching decoding on receive for the chosen encoding.
// - Received words are handed to the core on its own receive clock.
// - Low-speed out-of-band signalling is sent and detected while high-speed data is off.
`timescale 1ns/1ns
`default_nettype none
`include "stx_defs.svh"
module stx_datapath #(
  parameter bit WIDE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`STX_MAX_W-1:0] tx_word,
  output logic tx_serial,
  output logic tx_divided_clock,
  input wire logic rx_serial,
  input wire logic rx_fabric_clock,
  output logic [`STX_MAX_W-1:0] rx_word,
  output logic rx_word_valid
);
  localparam int W = `STX_MAX_W;
  localparam logic [5:0] ENC6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
    6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] ENC4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  function automatic logic [7:0] width_of(input logic [2:0] s);
    unique case (s)
      3'h0: return 8'd16;
      3'h1: return 8'd20;
      3'h2: return 8'd32;
      3'h3: return 8'd40;
      3'h4: return 8'd64;
      3'h5: return 8'd80;
      3'h6: return WIDE ? 8'd128 : 8'd80;
      3'h7: return WIDE ? 8'd160 : 8'd80;
    endcase
  endfunction

  function automatic logic [7:0] frame_len(input stx_pkg::stx_ctrl_t c);
    unique case (c.enc)
      stx_pkg::stx_enc_none: return width_of(c.width_sel);
      stx_pkg::stx_enc_8b10b: return 8'((width_of(c.width_sel) / 10) * 10);
      stx_pkg::stx_enc_64b66b: return 8'd66;
      stx_pkg::stx_enc_64b67b: return 8'd67;
    endcase
  endfunction

  // one 8B/10B symbol, returns {disparity, code}
  function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic rd);
    logic [5:0] a6;
    logic [3:0] b4;
    logic r;
    a6 = ENC6[d[4:0]];
    r = rd;
    if (r && ($countones(a6) != 3 || a6 == 6'h38)) a6 = ~a6;
    if ($countones(a6) != 3) r = ~r;
    b4 = ENC4[d[7:5]];
    if (r && ($countones(b4) != 2 || b4 == 4'hc)) b4 = ~b4;
    if ($countones(b4) != 2) r = ~r;
    return {r, b4, a6};
  endfunction

  // decode by search; either disparity is accepted, {error, byte}
  function automatic logic [8:0] dec8b10b(input logic [9:0] c);
    logic [8:0] res;
    res = 9'h100;
    for (int i = 0; i < 512; i++) begin
      if (enc8b10b(8'(i), i[8]) == {1'b0, c} || enc8b10b(8'(i), i[8]) == {1'b1, c}) begin
        res = {1'b0, 8'(i)};
      end
    end
    return res;
  endfunction

  stx_pkg::stx_ctrl_t ctrl_reg, ctrl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic oob_st_reg, oob_st_next, cerr_st_reg, cerr_st_next;
  logic [7:0] len;
  logic wr_en;
  assign len = frame_len(ctrl_reg);
  assign wr_en = psel && penable && pwrite && pready_reg;

  // Transmit state
  logic [7:0] tcnt_reg, tcnt_next, ocnt_reg, ocnt_next;
  logic [W-1:0] tsh_reg, tsh_next;
  logic [57:0] scr_reg, scr_next;
  logic trd_reg, trd_next, tser_reg, tser_next, tdiv_reg, tdiv_next, olvl_reg, olvl_next;

  always_comb begin
    logic [W-1:0] f;
    logic [63:0] sd;
    logic [10:0] e;
    f = '0;
    sd = '0;
    e = '0;
    tcnt_next = 8'h00;
    tsh_next = tsh_reg;
    scr_next = scr_reg;
    trd_next = trd_reg;
    ocnt_next = 8'h00;
    olvl_next = 1'b0;
    tser_next = 1'b0;
    tdiv_next = 1'b0;
    if (ctrl_reg.tx_en) begin
      if (tcnt_reg == 8'h00) begin
        // word sampled one pclk after the divided-clock rising edge, at that edge itself for the first word after tx enable
        unique case (ctrl_reg.enc)
          stx_pkg::stx_enc_none: f = tx_word;
          stx_pkg::stx_enc_8b10b: begin
            e[10] = trd_reg;
            for (int k = 0; k < W / 10; k++) begin
              if (k < len / 10) begin
                e = enc8b10b(tx_word[8*k +: 8], e[10]);
                f[10*k +: 10] = e[9:0];
              end
            end
            trd_next = e[10];
          end
          stx_pkg::stx_enc_64b66b, stx_pkg::stx_enc_64b67b: begin
            // self-synchronising scrambler behind the sync header
            for (int i = 0; i < 64; i++) begin
              sd[i] = tx_word[i] ^ scr_next[38] ^ scr_next[57];
              scr_next = {scr_next[56:0], sd[i]};
            end
            if (ctrl_reg.enc == stx_pkg::stx_enc_64b66b) f = {94'h0, sd, `STX_SYNC66};
            else f = {93'h0, sd, `STX_SYNC67};
          end
        endcase
        // NRZ, first bit of the word goes out first
        tser_next = f[0];
        tsh_next = f >> 1;
      end else begin
        tser_next = tsh_reg[0];
        tsh_next = tsh_reg >> 1;
      end
      tcnt_next = (tcnt_reg == len - 8'd1) ? 8'h00 : tcnt_reg + 8'd1;
      // divided clock high for the first half of each word
      tdiv_next = tcnt_next < (len >> 1);
    end else if (ctrl_reg.oob_tx) begin
      // low-speed square wave while data is off
      ocnt_next = (ocnt_reg == `STX_OOB_HALF - 8'd1) ? 8'h00 : ocnt_reg + 8'd1;
      olvl_next = (ocnt_reg == `STX_OOB_HALF - 8'd1) ? ~olvl_reg : olvl_reg;
      tser_next = olvl_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt_reg <= 8'h00;
      tsh_reg <= '0;
      scr_reg <= '1;
      trd_reg <= 1'b0;
      tser_reg <= 1'b0;
      tdiv_reg <= 1'b0;
      ocnt_reg <= 8'h00;
      olvl_reg <= 1'b0;
    end else begin
      tcnt_reg <= tcnt_next;
      tsh_reg <= tsh_next;
      scr_reg <= scr_next;
      trd_reg <= trd_next;
      tser_reg <= tser_next;
      tdiv_reg <= tdiv_next;
      ocnt_reg <= ocnt_next;
      olvl_reg <= olvl_next;
    end
  end

  // Receive state; the word boundary starts at rx enable, no bit slip
  logic [7:0] rcnt_reg, rcnt_next, run_reg, run_next;
  logic [W-1:0] rsh_reg, rsh_next, hold_reg, hold_next, rxw_reg, rxw_next;
  logic [57:0] dscr_reg, dscr_next;
  logic [3:0] burst_reg, burst_next;
  logic prev_reg, prev_next, lock_reg, lock_next, hvld_reg, hvld_next;
  logic fab_reg, rvld_reg, rvld_next, cerr_ev, oob_ev;

  always_comb begin
    logic [W-1:0] fr;
    logic [8:0] dd;
    logic trans;
    fr = '0;
    dd = '0;
    rcnt_next = 8'h00;
    rsh_next = rsh_reg;
    hold_next = hold_reg;
    hvld_next = hvld_reg;
    dscr_next = dscr_reg;
    cerr_ev = 1'b0;
    oob_ev = 1'b0;
    burst_next = burst_reg;
    trans = rx_serial != prev_reg;
    prev_next = rx_serial;
    // timing kept from transitions; long runs mean loss of lock
    run_next = trans ? 8'h00 : ((run_reg == 8'hff) ? run_reg : run_reg + 8'd1);
    lock_next = ctrl_reg.rx_en && (trans || run_reg < `STX_RUN_LIMIT - 8'd1);
    if (trans) begin
      // count runs of the out-of-band half period
      if (run_reg + 8'd2 >= `STX_OOB_HALF && run_reg <= `STX_OOB_HALF) begin
        burst_next = (burst_reg == `STX_OOB_BURSTS) ? burst_reg : burst_reg + 4'd1;
      end else begin
        burst_next = 4'h0;
      end
      oob_ev = !ctrl_reg.tx_en && burst_next == `STX_OOB_BURSTS;
    end
    if (ctrl_reg.rx_en) begin
      // shift in and cut one word every len bits
      rsh_next = {rx_serial, rsh_reg[W-1:1]};
      rcnt_next = (rcnt_reg == len - 8'd1) ? 8'h00 : rcnt_reg + 8'd1;
      if (rcnt_reg == len - 8'd1) begin
        fr = rsh_next >> (8'(W) - len);
        hvld_next = 1'b1;
        unique case (ctrl_reg.enc)
          stx_pkg::stx_enc_none: hold_next = fr;
          stx_pkg::stx_enc_8b10b: begin
            hold_next = '0;
            for (int k = 0; k < W / 10; k++) begin
              if (k < len / 10) begin
                dd = dec8b10b(fr[10*k +: 10]);
                hold_next[8*k +: 8] = dd[7:0];
                cerr_ev = cerr_ev | dd[8];
              end
            end
          end
          stx_pkg::stx_enc_64b66b, stx_pkg::stx_enc_64b67b: begin
            hold_next = '0;
            cerr_ev = fr[1] == fr[0];
            fr = (ctrl_reg.enc == stx_pkg::stx_enc_64b66b) ? fr >> 2 : fr >> 3;
            for (int i = 0; i < 64; i++) begin
              hold_next[i] = fr[i] ^ dscr_next[38] ^ dscr_next[57];
              dscr_next = {dscr_next[56:0], fr[i]};
            end
          end
        endcase
      end
    end
    // handover on the fabric clock rising edge
    rvld_next = rx_fabric_clock && !fab_reg && hvld_reg;
    rxw_next = rvld_next ? hold_reg : rxw_reg;
    if (rvld_next && !(ctrl_reg.rx_en && rcnt_reg == len - 8'd1)) hvld_next = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt_reg <= 8'h00;
      run_reg <= 8'h00;
      rsh_reg <= '0;
      hold_reg <= '0;
      rxw_reg <= '0;
      dscr_reg <= '1;
      burst_reg <= 4'h0;
      prev_reg <= 1'b0;
      lock_reg <= 1'b0;
      hvld_reg <= 1'b0;
      fab_reg <= 1'b0;
      rvld_reg <= 1'b0;
    end else begin
      rcnt_reg <= rcnt_next;
      run_reg <= run_next;
      rsh_reg <= rsh_next;
      hold_reg <= hold_next;
      rxw_reg <= rxw_next;
      dscr_reg <= dscr_next;
      burst_reg <= burst_next;
      prev_reg <= prev_next;
      lock_reg <= lock_next;
      hvld_reg <= hvld_next;
      fab_reg <= rx_fabric_clock;
      rvld_reg <= rvld_next;
    end
  end

  // Register bus: zero-wait, data prepared during the setup cycle
  always_comb begin
    pready_next = psel && !penable;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    ctrl_next = ctrl_reg;
    if (psel && !penable) begin
      prdata_next = 32'h0;
      if (paddr == `STX_CTRL_OFF) prdata_next = {24'h0, ctrl_reg};
      else if (paddr == `STX_STAT_OFF) prdata_next = {29'h0, cerr_st_reg, oob_st_reg, lock_reg};
      else pslverr_next = 1'b1;
    end
    if (wr_en && paddr == `STX_CTRL_OFF) ctrl_next = stx_pkg::stx_ctrl_t'(pwdata[7:0]);
    // A new event wins over a write-one clear in the same cycle
    oob_st_next = oob_ev || (oob_st_reg && !(wr_en && paddr == `STX_STAT_OFF
      && pwdata[`STX_ST_OOB]));
    cerr_st_next = cerr_ev || (cerr_st_reg && !(wr_en && paddr == `STX_STAT_OFF
      && pwdata[`STX_ST_CERR]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= stx_pkg::stx_ctrl_t'(`STX_CTRL_RST);
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      oob_st_reg <= 1'b0;
      cerr_st_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      oob_st_reg <= oob_st_next;
      cerr_st_reg <= cerr_st_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_serial = tser_reg;
  assign tx_divided_clock = tdiv_reg;
  assign rx_word = rxw_reg;
  assign rx_word_valid = rvld_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  tx_div_rise_a: assert property (ctrl_reg.tx_en && $past(ctrl_reg.tx_en) && tcnt_reg == len - 8'd1
    && len > 8'd1 && $stable(ctrl_reg) |=> tx_divided_clock)
    else $error("divided clock not high at word start");
  tx_first_bit_a: assert property (ctrl_reg.tx_en && tcnt_reg == 8'h00
    && ctrl_reg.enc == stx_pkg::stx_enc_none |=> tx_serial == $past(tx_word[0]))
    else $error("first serial bit not word bit 0");
  tx_sync_hdr_a: assert property (ctrl_reg.tx_en && tcnt_reg == 8'h00
    && ctrl_reg.enc == stx_pkg::stx_enc_64b66b |=> !tx_serial ##1 tx_serial)
    else $error("sync header wrong");
  tx_quiet_a: assert property (!ctrl_reg.tx_en && !ctrl_reg.oob_tx |=> !tx_serial)
    else $error("line not quiet when off");
  rx_lock_loss_a: assert property (run_reg >= `STX_RUN_LIMIT && !(rx_serial != prev_reg)
    |=> !lock_reg)
    else $error("lock kept over long run");
  rx_handover_a: assert property (rx_word_valid |-> rx_word == $past(hold_reg)
    && !$past(fab_reg) ##1 !rx_word_valid)
    else $error("handover not on fabric edge");
  oob_sticky_a: assert property (oob_ev |=> oob_st_reg)
    else $error("oob status not set");
  rx_word_count_a: assert property (ctrl_reg.rx_en && rcnt_reg == len - 8'd1 |=> hvld_reg)
    else $error("received word not held");

  cov_oob_seen_c: cover property (oob_ev);
  cov_rx_word_c: cover property (rx_word_valid && ctrl_reg.enc == stx_pkg::stx_enc_8b10b);
  cov_tx_wide_c: cover property (ctrl_reg.tx_en && len == 8'd160);
endmodule
`default_nettype wire

// ===== verif/stx_remote_model.sv
`timescale 1ns/1ns
`default_nettype none
module stx_remote_model (
  input wire logic pclk,
  input wire logic [1:0] mode,
  input wire logic go,
  input wire logic [159:0] frame,
  input wire logic [7:0] len,
  output logic line_out
);
  logic [159:0] sh_reg = '0;
  logic [7:0] left_reg = 8'h00;
  logic [2:0] oob_reg = 3'h0;
  logic oob_lvl = 1'b0;
  initial line_out = 1'b0;
  // plain NRZ bits, no clock sent, slow bursts when idle in mode 1
  always @(posedge pclk) begin
    oob_reg <= oob_reg + 3'h1;
    if (oob_reg == 3'h7)
      oob_lvl <= ~oob_lvl;
    if (go) begin
      line_out <= frame[0];
      sh_reg <= frame >> 1;
      left_reg <= len - 8'h01;
    end else if (left_reg != 8'h00) begin
      line_out <= sh_reg[0];
      sh_reg <= sh_reg >> 1;
      left_reg <= left_reg - 8'h01;
    end else if (mode == 2'h1)
      line_out <= oob_lvl;
    // Stuck level only on demand, to break receiver lock
    else if (mode == 2'h2)
      line_out <= 1'b0;
    // Idle line toggles so a stale level never looks like data
    else
      line_out <= ~line_out;
  end
endmodule
`default_nettype wire

// ===== verif/stx_datapath_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "stx_defs.svh"
module stx_datapath_tb;
  logic pclk, pready, pslverr, tx_serial, tx_divided_clock, rx_serial, rx_word_valid;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic rx_fabric_clock = 1'b0;
  logic go = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [159:0] rx_word, frame = '0;
  logic [159:0] tx_word = 160'h0123456789abcdef_fedcba9876543210_5a5ac3c3;
  logic [7:0] flen = 8'h00;
  int fail_count = 0;
  int n_compared = 0;
  int wtab[8] = '{16, 20, 32, 40, 64, 80, 128, 160};

  stx_datapath #(.WIDE(1'b1)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_word(tx_word), .tx_serial(tx_serial),
    .tx_divided_clock(tx_divided_clock), .rx_serial(rx_serial),
    .rx_fabric_clock(rx_fabric_clock), .rx_word(rx_word), .rx_word_valid(rx_word_valid));
  stx_remote_model u_far (.pclk(pclk), .mode(mode), .go(go), .frame(frame), .len(flen),
    .line_out(rx_serial));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic summarize;
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic hang;
    fail_count++;
    summarize();
  endtask

  task automatic cmp(input logic [159:0] got, input logic [159:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] w, input stx_pkg::stx_enc_t e,
                                      input logic tx, input logic rx, input logic out_of_band_signalling);
    stx_pkg::stx_ctrl_t c;
    c = '{oob_tx: out_of_band_signalling, rx_en: rx, tx_en: tx, enc: e, width_sel: w};
    return {24'h0, c};
  endfunction

  // Request held until pready is seen high; slave latency is not assumed
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) hang();
    end while (pready !== 1'b1);
    rd = prdata;
    cmp(160'(pslverr), 160'(e));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Finds the first word start after tx is enabled and collects len line bits
  task automatic grab(input int len, output logic [159:0] f, output int hi);
    int n;
    logic prev, cur;
    f = '0;
    hi = 0;
    cur = 1'b1;
    n = 0;
    do begin
      prev = cur;
      @(posedge pclk);
      cur = tx_divided_clock;
      n++;
      if (n > 400) hang();
    end while (!(prev === 1'b0 && cur === 1'b1));
    for (int i = 0; i < len; i++) begin
      if (i > 0) @(posedge pclk);
      f[i] = tx_serial;
      hi += (tx_divided_clock === 1'b1) ? 1 : 0;
    end
    apb(`STX_CTRL_OFF, 1'b1, 32'h0, 1'b0);
  endtask

  // Far side starts the frame so its first bit is the first one the receiver takes
  task automatic rx_send(input logic [31:0] c, input logic [159:0] f, input int len,
                         output logic [159:0] w);
    int n;
    frame <= f;
    flen <= len[7:0];
    fork
      apb(`STX_CTRL_OFF, 1'b1, c, 1'b0);
      begin
        repeat (2) @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
      end
    join
    repeat (len + 4) @(posedge pclk);
    rx_fabric_clock <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 10) hang();
    end while (rx_word_valid !== 1'b1);
    w = rx_word;
    rx_fabric_clock <= 1'b0;
    // Receiver off again so the next word boundary starts from a fresh count
    apb(`STX_CTRL_OFF, 1'b1, 32'h0, 1'b0);
  endtask

  task automatic t_regs;
    apb(`STX_CTRL_OFF, 1'b0, 32'h0, 1'b0);
    cmp(160'(rd), 160'(`STX_CTRL_RST));
    apb(`STX_STAT_OFF, 1'b0, 32'h0, 1'b0);
    cmp(160'(rd), 160'h0);
    apb(`STX_CTRL_OFF, 1'b1, 32'hffff_ff5a, 1'b0);
    apb(12'h008, 1'b1, 32'hffff_ffff, 1'b1);
    apb(12'h008, 1'b0, 32'h0, 1'b1);
    cmp(160'(rd), 160'h0);
    apb(`STX_CTRL_OFF, 1'b0, 32'h0, 1'b0);
    cmp(160'(rd), 160'h5a);
    apb(`STX_CTRL_OFF, 1'b1, 32'h0, 1'b0);
  endtask

  task automatic t_widths;
    logic [159:0] f;
    int hi;
    for (int s = 0; s < 8; s++) begin
      apb(`STX_CTRL_OFF, 1'b1, ctl(s[2:0], stx_pkg::stx_enc_none, 1'b1, 1'b0, 1'b0), 1'b0);
      grab(wtab[s], f, hi);
      cmp(f, tx_word & ((160'h1 << wtab[s]) - 160'h1));
      cmp(160'(hi), 160'(wtab[s] / 2));
    end
  endtask

  task automatic t_codes;
    logic [159:0] f, w;
    int hi;
    apb(`STX_CTRL_OFF, 1'b1, ctl(3'h4, stx_pkg::stx_enc_64b66b, 1'b1, 1'b0, 1'b0), 1'b0);
    grab(66, f, hi);
    cmp(160'(f[1:0]), 160'(`STX_SYNC66));
    cmp(160'(hi), 160'd33);
    apb(`STX_CTRL_OFF, 1'b1, ctl(3'h4, stx_pkg::stx_enc_64b67b, 1'b1, 1'b0, 1'b0), 1'b0);
    grab(67, f, hi);
    cmp(160'(f[2:0]), 160'(`STX_SYNC67));
    apb(`STX_CTRL_OFF, 1'b1, ctl(3'h1, stx_pkg::stx_enc_8b10b, 1'b1, 1'b0, 1'b0), 1'b0);
    grab(20, f, hi);
    rx_send(ctl(3'h1, stx_pkg::stx_enc_8b10b, 1'b0, 1'b1, 1'b0), f, 20, w);
    cmp(160'(w[15:0]), 160'(tx_word[15:0]));
    rx_send(ctl(3'h0, stx_pkg::stx_enc_none, 1'b0, 1'b1, 1'b0), tx_word, 16, w);
    cmp(160'(w[15:0]), 160'(tx_word[15:0]));
    rx_send(ctl(3'h7, stx_pkg::stx_enc_none, 1'b0, 1'b1, 1'b0), tx_word, 160, w);
    cmp(w, tx_word);
    apb(`STX_CTRL_OFF, 1'b1, 32'h0, 1'b0);
    apb(`STX_STAT_OFF, 1'b1, 32'h4, 1'b0);
    apb(`STX_STAT_OFF, 1'b0, 32'h0, 1'b0);
    cmp(160'(rd[2]), 160'h0);
    rx_send(ctl(3'h4, stx_pkg::stx_enc_64b66b, 1'b0, 1'b1, 1'b0), '0, 66, w);
    apb(`STX_STAT_OFF, 1'b0, 32'h0, 1'b0);
    cmp(160'(rd[2]), 160'h1);
    apb(`STX_CTRL_OFF, 1'b1, 32'h0, 1'b0);
  endtask

  task automatic t_oob;
    int n;
    logic last;
    mode <= 2'h1;
    apb(`STX_CTRL_OFF, 1'b1, ctl(3'h0, stx_pkg::stx_enc_none, 1'b0, 1'b1, 1'b1), 1'b0);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      last = tx_serial;
      do begin
        @(posedge pclk);
        n++;
        if (n > 20) hang();
      end while (tx_serial === last);
      if (k > 0) cmp(160'(n), 160'(`STX_OOB_HALF));
    end
    repeat (40) @(posedge pclk);
    apb(`STX_STAT_OFF, 1'b0, 32'h0, 1'b0);
    cmp(160'(rd[1:0]), 160'h3);
    mode <= 2'h0;
    apb(`STX_STAT_OFF, 1'b1, 32'h2, 1'b0);
    apb(`STX_STAT_OFF, 1'b0, 32'h0, 1'b0);
    cmp(160'(rd[1]), 160'h0);
    mode <= 2'h2;
    repeat (80) @(posedge pclk);
    apb(`STX_STAT_OFF, 1'b0, 32'h0, 1'b0);
    cmp(160'(rd[0]), 160'h0);
    mode <= 2'h0;
    apb(`STX_CTRL_OFF, 1'b1, 32'h0, 1'b0);
    // The bit launched at the write edge still comes from the old mode
    @(posedge pclk);
    repeat (16) begin
      @(posedge pclk);
      cmp(160'(tx_serial), 160'h0);
    end
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_widths();
    t_codes();
    t_oob();
    summarize();
  end
endmodule
`default_nettype wire
